/* rtl/ssq_pkg.sv */
// Constants and types shared by the sensor sample queue files
package ssq_pkg;

	// Storage geometry
	localparam int unsigned SSQ_DEPTH = 512;
	localparam int SSQ_AW = 9;
	localparam int SSQ_CW = 10;
	localparam logic [9:0] SSQ_FULL = 10'h200;
	localparam logic [9:0] SSQ_EMPTY_CNT = 10'h000;
	localparam int SSQ_SETS_XYZ = 170;
	localparam int SSQ_SETS_XYZT = 128;

	// Register port offsets and reset values
	localparam logic [7:0] SSQ_OFF_CTRL = 8'h28;
	localparam logic [7:0] SSQ_OFF_COUNT = 8'h29;
	localparam logic [7:0] SSQ_OFF_FILTER = 8'h2C;
	localparam logic [7:0] SSQ_CTRL_RST = 8'h00;
	localparam logic [7:0] SSQ_COUNT_RST = 8'h80;
	localparam logic [7:0] SSQ_FILTER_RST = 8'h00;
	localparam logic [7:0] SSQ_UNMAPPED = 8'h00;

	// Field positions
	localparam int SSQ_MODE_LSB = 0;
	localparam int SSQ_MODE_MSB = 1;
	localparam int SSQ_TEMP_BIT = 2;
	localparam int SSQ_AH_BIT = 3;
	localparam int SSQ_EXT_BIT = 3;

	typedef enum logic [1:0] {
		SSQ_OFF = 2'h0,
		SSQ_OLDEST = 2'h1,
		SSQ_STREAM = 2'h2,
		SSQ_TRIG = 2'h3
	} ssq_mode_t;

	// Entry type tags
	localparam logic [1:0] SSQ_TAG_X = 2'h0;
	localparam logic [1:0] SSQ_TAG_Y = 2'h1;
	localparam logic [1:0] SSQ_TAG_Z = 2'h2;
	localparam logic [1:0] SSQ_TAG_T = 2'h3;

	localparam logic [15:0] SSQ_EMPTY_WORD = 16'h0000;
	localparam logic [7:0] SSQ_EMPTY_BYTE = 8'h00;

	// Tag, two sign copies, then the 12-bit sample
	function automatic logic [15:0] ssq_entry(input logic [1:0] tag,
		input logic [11:0] d);
		return {tag, d[11], d[11], d};
	endfunction

endpackage

/* rtl/ssq_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ns
module ssq_sync
	import ssq_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic d_i,
	output logic q_o
);

	logic meta_reg;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end

endmodule

/* rtl/ssq_link_port.sv */
// Link-side byte server for buffer read commands
`timescale 1ns/1ns
module ssq_link_port
	import ssq_pkg::*;
(
	input wire logic link_clk_i,
	input wire logic reset_n_i,
	input wire logic link_cmd_i,
	input wire logic link_byte_take_i,
	input wire logic ack_tgl_i,
	input wire logic [15:0] word_i,
	output logic req_tgl_o,
	output logic pop_o,
	output logic [7:0] link_byte_o
);

	logic ack_s;
	logic ack_seen_reg;
	logic cmd_d_reg;
	logic busy_reg;
	logic valid_reg;
	logic high_reg;
	logic [15:0] word_reg;

	ssq_sync u_ack_sync (
		.clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.d_i(ack_tgl_i),
		.q_o(ack_s)
	);

	wire cmd_start = link_cmd_i & ~cmd_d_reg;
	wire ack_new = ack_s ^ ack_seen_reg;
	wire take = link_cmd_i & link_byte_take_i & valid_reg;
	wire pair_done = take & high_reg;
	wire refetch = cmd_start & ~busy_reg;
	// low byte first, then high byte
	wire [7:0] byte_next = !valid_reg ? SSQ_EMPTY_BYTE :
		(high_reg ? word_reg[15:8] : word_reg[7:0]);

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_seen_reg <= 1'b0;
			cmd_d_reg <= 1'b0;
			busy_reg <= 1'b0;
			valid_reg <= 1'b0;
			high_reg <= 1'b0;
			word_reg <= SSQ_EMPTY_WORD;
			req_tgl_o <= 1'b0;
			pop_o <= 1'b0;
			link_byte_o <= SSQ_EMPTY_BYTE;
		end else begin
			cmd_d_reg <= link_cmd_i;
			ack_seen_reg <= ack_s;
			link_byte_o <= byte_next;
			if (cmd_start) begin
				high_reg <= 1'b0;
			end
			if (refetch) begin
				pop_o <= 1'b0;
				req_tgl_o <= ~req_tgl_o;
				busy_reg <= 1'b1;
				valid_reg <= 1'b0;
			end else if (pair_done) begin
				// Commit the word just sent and fetch the next head
				pop_o <= 1'b1;
				req_tgl_o <= ~req_tgl_o;
				busy_reg <= 1'b1;
				valid_reg <= 1'b0;
				high_reg <= 1'b0;
			end else if (ack_new) begin
				word_reg <= word_i;
				valid_reg <= 1'b1;
				busy_reg <= 1'b0;
			end else if (take) begin
				high_reg <= 1'b1;
			end
		end
	end

endmodule

/* rtl/ssq_core.sv */
// Sensor sample queue: storage, modes, flags and register port
`timescale 1ns/1ns

// What this block does
// - Trigger pin pulse acquires one sample set
// - Storage of 512 sixteen-bit entries
// - Holds 170 xyz or 128 xyzt sets
// - Mode 00 stores nothing, clears contents
// - Mode 01 keeps oldest, drops when full
// - Mode 10 keeps newest, discards oldest
// - Stream raises watermark at programmed count
// - Mode 11 keeps programmed pre-event entries
// - Read command only, low byte first
// - Data, sign copies, type tag layout
// - Tags: X 00, Y 01, Z 10, temp 11
// - Reads past empty return zero bytes
// - Writes X, Y, Z, then optional temp
// - Auxiliary converter data never stored
// - Partial set stored when space short
// - Each read frees exactly one entry
// - Ready, watermark and overrun conditions
// - Watermark while count at or above level
// - Overrun on loss, cleared by read
// - Ready while any valid entry held
module ssq_core
	import ssq_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic link_clk_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic sample_strobe_i,
	input wire logic [11:0] accel_x_i,
	input wire logic [11:0] accel_y_i,
	input wire logic [11:0] accel_z_i,
	input wire logic [11:0] temp_i,
	input wire logic activity_i,
	input wire logic second_interrupt_pin_i,
	input wire logic link_cmd_i,
	input wire logic link_byte_take_i,
	output logic [7:0] link_byte_o,
	output logic set_acquired_o,
	output logic ready_o,
	output logic watermark_o,
	output logic overrun_o
);

	typedef enum logic [4:0] {
		SSQ_W_IDLE = 5'b00001,
		SSQ_W_X = 5'b00010,
		SSQ_W_Y = 5'b00100,
		SSQ_W_Z = 5'b01000,
		SSQ_W_T = 5'b10000
	} ssq_wstate_t;

	logic [15:0] mem [0:SSQ_DEPTH-1];

	logic [SSQ_AW-1:0] wr_ptr_reg;
	logic [SSQ_AW-1:0] rd_ptr_reg;
	logic [SSQ_CW-1:0] count_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] count_cfg_reg;
	logic [7:0] filter_reg;
	ssq_wstate_t state_reg;
	ssq_wstate_t state_next;
	logic [11:0] x_reg;
	logic [11:0] y_reg;
	logic [11:0] z_reg;
	logic [11:0] t_reg;
	logic trig_d_reg;
	logic req_d_reg;
	logic ack_tgl_reg;
	logic [15:0] resp_word_reg;
	logic peek_valid_reg;
	logic hit_reg;
	logic done_reg;

	logic trig_s;
	logic req_s;
	logic link_req_tgl;
	logic link_pop;

	// Trigger pin is asynchronous to this clock
	ssq_sync u_trig_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.d_i(second_interrupt_pin_i),
		.q_o(trig_s)
	);

	ssq_sync u_req_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.d_i(link_req_tgl),
		.q_o(req_s)
	);

	// link domain serves bytes of handed-over words
	ssq_link_port u_link (
		.link_clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.link_cmd_i(link_cmd_i),
		.link_byte_take_i(link_byte_take_i),
		.ack_tgl_i(ack_tgl_reg),
		.word_i(resp_word_reg),
		.req_tgl_o(link_req_tgl),
		.pop_o(link_pop),
		.link_byte_o(link_byte_o)
	);

	wire ssq_mode_t mode = ssq_mode_t'(ctrl_reg[SSQ_MODE_MSB:SSQ_MODE_LSB]);
	wire temp_en = ctrl_reg[SSQ_TEMP_BIT];
	wire ext_en = filter_reg[SSQ_EXT_BIT];
	wire enabled = mode != SSQ_OFF;
	wire ctrl_wr = reg_wr_i && reg_addr_i == SSQ_OFF_CTRL;

	// level is {high count bit, count register}
	wire [SSQ_CW-1:0] level = {1'b0, ctrl_reg[SSQ_AH_BIT], count_cfg_reg};

	// one set per rising trigger edge
	// pulse is high-going from a low idle
	wire trig_rise = trig_s & ~trig_d_reg;
	wire start_src = ext_en ? trig_rise : sample_strobe_i;
	wire set_start = state_reg == SSQ_W_IDLE && start_src;

	// X, Y, Z, then temperature if enabled
	// three or four entries per set
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SSQ_W_IDLE: begin
				if (set_start) begin
					state_next = SSQ_W_X;
				end
			end
			SSQ_W_X: begin
				state_next = SSQ_W_Y;
			end
			SSQ_W_Y: begin
				state_next = SSQ_W_Z;
			end
			SSQ_W_Z: begin
				state_next = temp_en ? SSQ_W_T : SSQ_W_IDLE;
			end
			SSQ_W_T: begin
				state_next = SSQ_W_IDLE;
			end
			default: begin
				state_next = SSQ_W_IDLE;
			end
		endcase
	end

	// only accel and temperature inputs exist
	wire [15:0] wr_word =
		(state_reg == SSQ_W_X) ? ssq_entry(SSQ_TAG_X, x_reg) :
		(state_reg == SSQ_W_Y) ? ssq_entry(SSQ_TAG_Y, y_reg) :
		(state_reg == SSQ_W_Z) ? ssq_entry(SSQ_TAG_Z, z_reg) :
		ssq_entry(SSQ_TAG_T, t_reg);
	wire wr_attempt = enabled && state_reg != SSQ_W_IDLE;

	// host commits only after a whole word
	// one entry freed per committed word
	wire req_edge = req_s ^ req_d_reg;
	wire pop_req = req_edge && link_pop && peek_valid_reg && enabled;
	wire [SSQ_CW-1:0] cnt_after_pop = count_reg -
		{{(SSQ_CW-1){1'b0}}, pop_req};
	wire room = cnt_after_pop != SSQ_FULL;

	wire trig_mode = mode == SSQ_TRIG;
	wire trig_pre = trig_mode && !hit_reg;
	wire trig_post = trig_mode && hit_reg;

	// pre-event keeps at most level entries
	// partial sets stored entry by entry
	wire store_ok = (mode == SSQ_OLDEST && room) ||
		mode == SSQ_STREAM ||
		(trig_pre && level != SSQ_EMPTY_CNT) ||
		(trig_post && !done_reg && room);
	wire [SSQ_CW-1:0] limit = trig_pre ? level : SSQ_FULL;
	wire discard = wr_attempt && store_ok &&
		(mode == SSQ_STREAM || trig_pre) && cnt_after_pop >= limit;
	wire do_write = wr_attempt && store_ok;
	wire dropped = wr_attempt && !store_ok && !trig_pre;

	wire [SSQ_CW-1:0] cnt_no_wr = cnt_after_pop -
		{{(SSQ_CW-1){1'b0}}, discard};
	wire [SSQ_CW-1:0] count_next = !enabled ? SSQ_EMPTY_CNT :
		cnt_no_wr + {{(SSQ_CW-1){1'b0}}, do_write};
	wire [SSQ_AW-1:0] rd_next = rd_ptr_reg +
		{{(SSQ_AW-1){1'b0}}, pop_req} + {{(SSQ_AW-1){1'b0}}, discard};

	// empty buffer answers with a zero word
	wire head_avail = enabled && cnt_no_wr != SSQ_EMPTY_CNT;
	wire [15:0] head_word = head_avail ? mem[rd_next] : SSQ_EMPTY_WORD;

	// loss sets overrun; read or disable clears
	wire ovr_set = discard || dropped;
	wire ovr_clr = pop_req || !enabled;
	wire ovr_next = ovr_set || (overrun_o && !ovr_clr);

	wire hit_next = (trig_mode && activity_i) ||
		(hit_reg && !ctrl_wr);
	wire done_next = ctrl_wr ? 1'b0 :
		(done_reg || (trig_post && count_next == SSQ_FULL));

	wire [7:0] rdata_next =
		(reg_addr_i == SSQ_OFF_CTRL) ? ctrl_reg :
		(reg_addr_i == SSQ_OFF_COUNT) ? count_cfg_reg :
		(reg_addr_i == SSQ_OFF_FILTER) ? filter_reg :
		SSQ_UNMAPPED;

	always_ff @(posedge clk_i) begin
		if (do_write) begin
			mem[wr_ptr_reg] <= wr_word;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_reg <= SSQ_CTRL_RST;
			count_cfg_reg <= SSQ_COUNT_RST;
			filter_reg <= SSQ_FILTER_RST;
			reg_rdata_o <= SSQ_UNMAPPED;
		end else begin
			reg_rdata_o <= rdata_next;
			if (ctrl_wr) begin
				ctrl_reg <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == SSQ_OFF_COUNT) begin
				count_cfg_reg <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == SSQ_OFF_FILTER) begin
				filter_reg <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= SSQ_W_IDLE;
			trig_d_reg <= 1'b0;
			x_reg <= 12'h000;
			y_reg <= 12'h000;
			z_reg <= 12'h000;
			t_reg <= 12'h000;
			set_acquired_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			trig_d_reg <= trig_s;
			set_acquired_o <= set_start;
			if (set_start) begin
				x_reg <= accel_x_i;
				y_reg <= accel_y_i;
				z_reg <= accel_z_i;
				t_reg <= temp_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= SSQ_EMPTY_CNT;
			hit_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			hit_reg <= hit_next;
			done_reg <= done_next;
			if (!enabled) begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
			end else begin
				rd_ptr_reg <= rd_next;
				if (do_write) begin
					wr_ptr_reg <= wr_ptr_reg + {{(SSQ_AW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// Word handover to the link domain
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_d_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
			resp_word_reg <= SSQ_EMPTY_WORD;
			peek_valid_reg <= 1'b0;
		end else begin
			req_d_reg <= req_s;
			if (req_edge) begin
				resp_word_reg <= head_word;
				peek_valid_reg <= head_avail;
				ack_tgl_reg <= ~ack_tgl_reg;
			end else if (!enabled) begin
				peek_valid_reg <= 1'b0;
			end
		end
	end

	// watermark in every mode from the same level
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ready_o <= 1'b0;
			watermark_o <= 1'b0;
			overrun_o <= 1'b0;
		end else begin
			ready_o <= count_next != SSQ_EMPTY_CNT;
			watermark_o <= count_next >= level;
			overrun_o <= ovr_next;
		end
	end

endmodule

/* sim/ssq_core_sva.sv */
// Checker of flag and acquisition timing at the queue ports
`timescale 1ns/1ns
module ssq_core_sva
	import ssq_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic sample_strobe_i,
	input wire logic second_interrupt_pin_i,
	input wire logic set_acquired_o,
	input wire logic ready_o,
	input wire logic watermark_o,
	input wire logic overrun_o
);
	logic [7:0] ctl_reg;
	logic [7:0] cnt_reg;
	logic [7:0] flt_reg;
	logic [2:0] since_reg;
	wire [8:0] lvl = {ctl_reg[SSQ_AH_BIT], cnt_reg};
	wire off = ctl_reg[1:0] == SSQ_OFF;
	wire ext = flt_reg[SSQ_EXT_BIT];
	wire wr_ctl = reg_wr_i && reg_addr_i == SSQ_OFF_CTRL;
	wire wr_cnt = reg_wr_i && reg_addr_i == SSQ_OFF_COUNT;
	wire wr_flt = reg_wr_i && reg_addr_i == SSQ_OFF_FILTER;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl_reg <= SSQ_CTRL_RST;
			cnt_reg <= SSQ_COUNT_RST;
			flt_reg <= SSQ_FILTER_RST;
		end else begin
			ctl_reg <= wr_ctl ? reg_wdata_i : ctl_reg;
			cnt_reg <= wr_cnt ? reg_wdata_i : cnt_reg;
			flt_reg <= wr_flt ? reg_wdata_i : flt_reg;
		end
	end
	// Cycles since the last captured set
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			since_reg <= 3'h7;
		end else begin
			since_reg <= set_acquired_o ? 3'h0 :
				since_reg + {2'h0, since_reg != 3'h7};
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_off_clears;
		off [*3] |-> !ready_o && !overrun_o;
	endproperty
	property p_set_gap;
		set_acquired_o |=> !set_acquired_o [*3];
	endproperty
	property p_ready_set;
		set_acquired_o && ctl_reg[1] != ctl_reg[0] |-> ##[1:4] ready_o;
	endproperty
	property p_wm_zero;
		(lvl == 9'h000) [*3] |-> watermark_o;
	endproperty
	property p_wm_empty;
		(lvl != 9'h000 && !ready_o) [*3] |-> !watermark_o;
	endproperty
	property p_ovr_cause;
		$rose(overrun_o) |-> since_reg <= 3'h6;
	endproperty
	property p_ext_trig;
		$rose(second_interrupt_pin_i) && ext |-> ##[1:6] set_acquired_o;
	endproperty
	property p_ext_quiet;
		(ext && !second_interrupt_pin_i) [*6] |-> !set_acquired_o;
	endproperty
	property p_strobe_only;
		(!ext && !sample_strobe_i) [*2] |-> !set_acquired_o;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("off mode");
	a_set_gap: assert property (p_set_gap) else $error("set spacing");
	a_ready_set: assert property (p_ready_set) else $error("no ready");
	a_wm_zero: assert property (p_wm_zero) else $error("wm zero");
	a_wm_empty: assert property (p_wm_empty) else $error("wm empty");
	a_ovr_cause: assert property (p_ovr_cause) else $error("overrun");
	a_ext_trig: assert property (p_ext_trig) else $error("no trig set");
	a_ext_quiet: assert property (p_ext_quiet) else $error("trig set");
	a_strobe_only: assert property (p_strobe_only) else $error("set");
	cover property (set_acquired_o && ext);
	cover property ($rose(overrun_o));
	cover property ($fell(watermark_o));
endmodule
bind ssq_core ssq_core_sva chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.sample_strobe_i(sample_strobe_i), .set_acquired_o(set_acquired_o),
	.second_interrupt_pin_i(second_interrupt_pin_i), .ready_o(ready_o),
	.watermark_o(watermark_o), .overrun_o(overrun_o));

/* sim/ssq_host_model.sv */
// Host reader model on the link side of the queue
`timescale 1ns/1ns
module ssq_host_model (
	input wire logic [7:0] link_byte_i,
	output logic link_clk_o,
	output logic link_cmd_o,
	output logic link_byte_take_o
);
	logic [15:0] got_q [$];
	logic [7:0] lo_byte;
	initial begin
		link_clk_o = 1'b0;
		link_cmd_o = 1'b0;
		link_byte_take_o = 1'b0;
	end
	// Clock runs only during a read, including two cycles before and after the command
	task automatic tick(input int n);
		repeat (n) begin
			#80 link_clk_o = 1'b1;
			#80 link_clk_o = 1'b0;
		end
	endtask
	task automatic take;
		link_byte_take_o = 1'b1;
		tick(1);
		link_byte_take_o = 1'b0;
		tick(8);
	endtask
	task automatic read_words(input int n);
		got_q.delete();
		#7 tick(2);
		link_cmd_o = 1'b1;
		tick(8);
		repeat (n) begin
			lo_byte = link_byte_i;
			take();
			got_q.push_back({link_byte_i, lo_byte});
			take();
		end
		link_cmd_o = 1'b0;
		tick(2);
	endtask
endmodule

/* sim/sensor_sample_queue_tb.sv */
// Self-checking bench for the sensor sample queue
`timescale 1ns/1ns
module sensor_sample_queue_tb
	import ssq_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic strb = 1'b0;
	logic act = 1'b0;
	logic trig = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdat = 8'h00;
	logic [11:0] dx = 12'h000, dy = 12'h000, dz = 12'h000, dt = 12'h000;
	logic [7:0] rdat, lbyte;
	logic lclk, lcmd, ltake, setacq, rdy, wm, ovr;
	int bad_count = 0;
	int n_compared = 0;
	always #20 clk = ~clk;
	ssq_core dut (.clk_i(clk), .reset_n_i(rst_n), .link_clk_i(lclk),
		.reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdat),
		.reg_rdata_o(rdat), .sample_strobe_i(strb), .accel_x_i(dx),
		.accel_y_i(dy), .accel_z_i(dz), .temp_i(dt), .activity_i(act),
		.second_interrupt_pin_i(trig), .link_cmd_i(lcmd),
		.link_byte_take_i(ltake), .link_byte_o(lbyte),
		.set_acquired_o(setacq), .ready_o(rdy), .watermark_o(wm),
		.overrun_o(ovr));
	ssq_host_model host (.link_byte_i(lbyte), .link_clk_o(lclk),
		.link_cmd_o(lcmd), .link_byte_take_o(ltake));
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk_w(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_f(input string nm, input logic e, g);
		chk_w(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		#2 wr = 1'b1;
		addr = a;
		wdat = d;
		@(posedge clk);
		#2 wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, e);
		@(posedge clk);
		#2 addr = a;
		@(posedge clk);
		#2 chk_w("register", {8'h00, e}, {8'h00, rdat});
	endtask
	function automatic logic [11:0] dv(input int s, input logic [1:0] a);
		logic [11:0] b;
		b = (a == 2'h0) ? 12'h100 : (a == 2'h1) ? 12'h8A0 :
			(a == 2'h2) ? 12'h0F5 : 12'hC30;
		return b + s[11:0];
	endfunction
	function automatic logic [15:0] ew(input int s, input logic [1:0] a);
		logic [11:0] d;
		d = dv(s, a);
		return {a, d[11], d[11], d};
	endfunction
	task automatic sets(input int from, n, input logic ext);
		for (int s = from; s < from + n; s++) begin
			@(posedge clk);
			#2 dx = dv(s, 2'h0);
			dy = dv(s, 2'h1);
			dz = dv(s, 2'h2);
			dt = dv(s, 2'h3);
			strb = 1'b1;
			trig = ext;
			@(posedge clk);
			#2 strb = 1'b0;
			repeat (3) @(posedge clk);
			#2 trig = 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask
	initial begin
		#2000000 bad_count++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		#2 rst_n = 1'b1;
		rd_reg(SSQ_OFF_CTRL, 8'h00);
		rd_reg(SSQ_OFF_COUNT, 8'h80);
		rd_reg(SSQ_OFF_FILTER, 8'h00);
		rd_reg(8'h2A, 8'h00);
		wr_reg(SSQ_OFF_CTRL, 8'h05);
		sets(0, 2, 1'b0);
		chk_f("ready", 1'b1, rdy);
		host.read_words(9);
		for (int i = 0; i < 8; i++) begin
			chk_w("word", ew(i / 4, 2'(i)), host.got_q[i]);
		end
		chk_w("word", 16'h0000, host.got_q[8]);
		chk_f("ready", 1'b0, rdy);
		wr_reg(SSQ_OFF_COUNT, 8'h03);
		wr_reg(SSQ_OFF_CTRL, 8'h01);
		sets(2, 1, 1'b0);
		chk_f("watermark", 1'b1, wm);
		host.read_words(1);
		chk_w("word", ew(2, 2'h0), host.got_q[0]);
		chk_f("watermark", 1'b0, wm);
		chk_f("ready", 1'b1, rdy);
		wr_reg(SSQ_OFF_CTRL, 8'h00);
		wr_reg(SSQ_OFF_COUNT, 8'h00);
		wr_reg(SSQ_OFF_CTRL, 8'h09);
		sets(0, 85, 1'b0);
		chk_f("watermark", 1'b0, wm);
		sets(85, 85, 1'b0);
		chk_f("watermark", 1'b1, wm);
		chk_f("overrun", 1'b0, ovr);
		sets(170, 1, 1'b0);
		chk_f("overrun", 1'b1, ovr);
		host.read_words(1);
		chk_w("word", ew(0, 2'h0), host.got_q[0]);
		chk_f("overrun", 1'b0, ovr);
		sets(171, 1, 1'b0);
		chk_f("overrun", 1'b1, ovr);
		wr_reg(SSQ_OFF_CTRL, 8'h00);
		@(posedge clk);
		#2 chk_f("ready", 1'b0, rdy);
		chk_f("overrun", 1'b0, ovr);
		wr_reg(SSQ_OFF_CTRL, 8'h0A);
		sets(0, 171, 1'b0);
		chk_f("watermark", 1'b1, wm);
		chk_f("overrun", 1'b1, ovr);
		host.read_words(2);
		chk_w("word", ew(0, 2'h1), host.got_q[0]);
		chk_w("word", ew(0, 2'h2), host.got_q[1]);
		wr_reg(SSQ_OFF_CTRL, 8'h00);
		wr_reg(SSQ_OFF_FILTER, 8'h08);
		wr_reg(SSQ_OFF_CTRL, 8'h01);
		sets(0, 2, 1'b1);
		host.read_words(7);
		for (int i = 0; i < 6; i++) begin
			chk_w("word", ew(i / 3, 2'(i % 3)), host.got_q[i]);
		end
		chk_w("word", 16'h0000, host.got_q[6]);
		wr_reg(SSQ_OFF_FILTER, 8'h00);
		wr_reg(SSQ_OFF_COUNT, 8'h02);
		wr_reg(SSQ_OFF_CTRL, 8'h03);
		sets(0, 3, 1'b0);
		@(posedge clk);
		#2 act = ~act;
		@(posedge clk);
		#2 act = ~act;
		sets(3, 1, 1'b0);
		host.read_words(6);
		chk_w("word", ew(2, 2'h1), host.got_q[0]);
		chk_w("word", ew(2, 2'h2), host.got_q[1]);
		for (int i = 0; i < 3; i++) begin
			chk_w("word", ew(3, 2'(i)), host.got_q[i + 2]);
		end
		chk_w("word", 16'h0000, host.got_q[5]);
		print_verdict();
	end
endmodule
